/* File: src/atc_top.sv */
/*
 * Aperture translation control: configuration registers, aperture decode,
 * translation buffer control and table entry fetch.
 * Assumes a configuration port and a memory port on the same clock.
 */
// Functional notes
// - Enable bit set: buffer caches translations
// - Enable clear: all buffer valid bits cleared
// - Disabled: every aperture request fetches table
// - Disabled: fetched entries are never cached
// - Invalid entries still cached, replacing LRU
// - Enable change flushes graphics write buffer
// - Enable may change mid lookup safely
// - Fast block set: rate bit two reads zero
// - Size bit zero: base bit 25 hardwired
// - Size bit one: base bit 25 writable
// - Size bit picks 64 MB or 32 MB
// - Reset aperture is 64 MB
// - Fast block set: rate bit two writes ignored
// - Table base is 4 KB aligned
`timescale 1ns/1ns
module atc_top
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  input wire logic [31:0] i_table_base,
  input wire logic i_xl_req,
  input wire logic [31:0] i_xl_addr,
  output logic o_xl_busy,
  output logic o_xl_done,
  output logic [31:0] o_xl_addr,
  output logic o_xl_hit_aper,
  output logic o_xl_fault,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_data,
  output logic o_gwb_flush,
  output logic [2:0] o_rate,
  output logic o_aper_32mb
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_FETCH} atc_state_type;

  atc_state_type state_r;
  logic tlb_en_r;
  logic fast_block_r;
  logic size_sel_r;
  logic [6:0] base_r;
  logic [2:0] rate_r;
  logic [31:0] req_addr_r;
  logic tlb_hit;
  atc_pkg::atc_pte_type tlb_pte;
  atc_pkg::atc_pte_type mem_pte;
  atc_pkg::atc_fill_type fill_data;
  logic tlb_fill;
  logic tlb_touch;
  logic in_aper;
  logic [atc_pkg::IDX_W-1:0] req_idx;
  logic wr_ctl;
  logic wr_size;
  logic wr_base;
  logic wr_stat;
  logic [31:0] rd_nxt;

  function automatic logic [31:0] xlate(input logic [31:0] addr,
                                        input atc_pkg::atc_pte_type pte);
    xlate = {pte.page, addr[atc_pkg::PAGE_LSB-1:0]};
  endfunction : xlate

  assign wr_ctl = i_cfg_wr && i_cfg_addr == atc_pkg::AGP_CONTROL_OFS;
  assign wr_size = i_cfg_wr && i_cfg_addr == atc_pkg::APER_SIZE_OFS;
  assign wr_base = i_cfg_wr && i_cfg_addr == atc_pkg::APER_BASE_OFS;
  assign wr_stat = i_cfg_wr && i_cfg_addr == atc_pkg::AGP_STATUS_OFS;

  // Control register; only bits 7 and 0 exist
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      tlb_en_r <= atc_pkg::AGP_CONTROL_RST[atc_pkg::TLB_EN_BIT];
      fast_block_r <= atc_pkg::AGP_CONTROL_RST[atc_pkg::FAST_BLOCK_BIT];
    end
    else if (wr_ctl)
    begin
      tlb_en_r <= i_cfg_wdata[atc_pkg::TLB_EN_BIT];
      fast_block_r <= i_cfg_wdata[atc_pkg::FAST_BLOCK_BIT];
    end
  end

  // Pulse only on a real change of the enable bit
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_gwb_flush <= 1'b0;
    end
    else
    begin
      o_gwb_flush <= wr_ctl &&
        i_cfg_wdata[atc_pkg::TLB_EN_BIT] != tlb_en_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      size_sel_r <= atc_pkg::APER_SIZE_RST[atc_pkg::SIZE_BIT];
    end
    else if (wr_size)
    begin
      size_sel_r <= i_cfg_wdata[atc_pkg::SIZE_BIT];
    end
  end

  // Base bits 31:25; bit 25 held at zero while the 64 MB size is chosen
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      base_r <= atc_pkg::APER_BASE_RST;
    end
    else if (wr_base)
    begin
      base_r <= {i_cfg_wdata[31:26],
                 i_cfg_wdata[atc_pkg::BASE_SEL_BIT] & size_sel_r};
    end
    else if (!size_sel_r)
    begin
      base_r[0] <= 1'b0;
    end
  end

  // Rate field; bit 2 frozen while the fast rate is blocked
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      rate_r <= atc_pkg::RATE_RST;
    end
    else if (wr_stat)
    begin
      rate_r[1:0] <= i_cfg_wdata[1:0];
      if (!fast_block_r)
      begin
        rate_r[atc_pkg::RATE_FAST_BIT] <=
          i_cfg_wdata[atc_pkg::RATE_FAST_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_rate <= atc_pkg::RATE_RST;
      o_aper_32mb <= 1'b0;
    end
    else
    begin
      o_rate <= {rate_r[2] & ~fast_block_r, rate_r[1:0]};
      o_aper_32mb <= size_sel_r;
    end
  end

  always_comb
  begin
    rd_nxt = '0;
    unique case (i_cfg_addr)
      atc_pkg::AGP_CONTROL_OFS:
      begin
        rd_nxt[atc_pkg::TLB_EN_BIT] = tlb_en_r;
        rd_nxt[atc_pkg::FAST_BLOCK_BIT] = fast_block_r;
      end
      atc_pkg::APER_SIZE_OFS:
      begin
        rd_nxt[atc_pkg::SIZE_BIT] = size_sel_r;
      end
      atc_pkg::APER_BASE_OFS:
      begin
        // Masked here too, so a read right after a size clear is zero
        rd_nxt[31:25] = {base_r[6:1], base_r[0] & size_sel_r};
      end
      atc_pkg::AGP_STATUS_OFS:
      begin
        rd_nxt[2:0] = {rate_r[2] & ~fast_block_r, rate_r[1:0]};
      end
      default:
      begin
        rd_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_cfg_rdata <= '0;
      o_cfg_rvalid <= 1'b0;
    end
    else
    begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd)
      begin
        o_cfg_rdata <= rd_nxt;
      end
    end
  end

  // 32 MB aperture compares one more base bit
  assign in_aper = req_addr_r[31:26] == base_r[6:1] &&
                   (!size_sel_r || req_addr_r[25] == base_r[0]);
  assign req_idx = {req_addr_r[25] & ~size_sel_r, req_addr_r[24:12]};
  assign mem_pte = atc_pkg::atc_pte_type'(i_mem_data);
  assign fill_data = '{idx: req_idx, pte: mem_pte};
  // Enable sampled at fill time, so a late clear never caches
  assign tlb_fill = state_r == ST_FETCH && i_mem_ack && tlb_en_r;
  // Lookups outside the aperture must not age the entries
  assign tlb_touch = state_r == ST_LOOK && tlb_en_r && in_aper;

  atc_tlb u_tlb
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_flush(!tlb_en_r),
    .i_look_idx(req_idx),
    .i_touch(tlb_touch),
    .i_fill(tlb_fill),
    .i_fill_data(fill_data),
    .o_hit(tlb_hit),
    .o_hit_pte(tlb_pte)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      state_r <= ST_IDLE;
      o_xl_busy <= 1'b0;
      o_mem_req <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (i_xl_req)
          begin
            state_r <= ST_LOOK;
            o_xl_busy <= 1'b1;
          end
        end
        ST_LOOK:
        begin
          if (in_aper && !(tlb_en_r && tlb_hit))
          begin
            state_r <= ST_FETCH;
            o_mem_req <= 1'b1;
          end
          else
          begin
            state_r <= ST_IDLE;
            o_xl_busy <= 1'b0;
          end
        end
        ST_FETCH:
        begin
          if (i_mem_ack)
          begin
            state_r <= ST_IDLE;
            o_xl_busy <= 1'b0;
            o_mem_req <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      req_addr_r <= '0;
      o_mem_addr <= '0;
    end
    else
    begin
      if (state_r == ST_IDLE && i_xl_req)
      begin
        req_addr_r <= i_xl_addr;
      end
      if (state_r == ST_LOOK)
      begin
        o_mem_addr <= {i_table_base[31:atc_pkg::PAGE_LSB], 12'h000} +
                      {16'h0000, req_idx, 2'h0};
      end
    end
  end

  // Result comes from the path chosen when the lookup started
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_xl_done <= 1'b0;
      o_xl_addr <= '0;
      o_xl_hit_aper <= 1'b0;
      o_xl_fault <= 1'b0;
    end
    else
    begin
      o_xl_done <= 1'b0;
      if (state_r == ST_LOOK && !in_aper)
      begin
        o_xl_done <= 1'b1;
        o_xl_addr <= req_addr_r;
        o_xl_hit_aper <= 1'b0;
        o_xl_fault <= 1'b0;
      end
      else if (state_r == ST_LOOK && tlb_en_r && tlb_hit)
      begin
        o_xl_done <= 1'b1;
        o_xl_addr <= xlate(req_addr_r, tlb_pte);
        o_xl_hit_aper <= 1'b1;
        o_xl_fault <= !tlb_pte.valid;
      end
      else if (state_r == ST_FETCH && i_mem_ack)
      begin
        o_xl_done <= 1'b1;
        o_xl_addr <= xlate(req_addr_r, mem_pte);
        o_xl_hit_aper <= 1'b1;
        o_xl_fault <= !mem_pte.valid;
      end
    end
  end
endmodule : atc_top

/* File: pkg/atc_pkg.sv */
/*
 * Constants and types for the aperture translation control block.
 * Assumes a 32-bit configuration port and a 32-bit table entry format.
 */
package atc_pkg;
  // Configuration offsets
  localparam logic [7:0] AGP_CONTROL_OFS = 8'hb0;
  localparam logic [7:0] APER_SIZE_OFS = 8'hb4;
  localparam logic [7:0] APER_BASE_OFS = 8'h10;
  localparam logic [7:0] AGP_STATUS_OFS = 8'ha4;
  // Field positions
  localparam int TLB_EN_BIT = 7;
  localparam int FAST_BLOCK_BIT = 0;
  localparam int SIZE_BIT = 3;
  localparam int BASE_SEL_BIT = 25;
  localparam int RATE_FAST_BIT = 2;
  localparam int RATE_W = 3;
  localparam int PAGE_LSB = 12;
  localparam int IDX_W = 14;
  // Reset values
  localparam logic [31:0] AGP_CONTROL_RST = 32'h0000_0000;
  localparam logic [7:0] APER_SIZE_RST = 8'h00;
  localparam logic [6:0] APER_BASE_RST = 7'h00;
  localparam logic [2:0] RATE_RST = 3'h1;
  // Translation buffer geometry
  localparam int TLB_ENTRIES = 4;
  localparam int TLB_IW = 2;

  typedef struct packed {
    logic [19:0] page;
    logic [10:0] rsvd;
    logic valid;
  } atc_pte_type;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    atc_pte_type pte;
  } atc_fill_type;
endpackage : atc_pkg

/* File: src/atc_tlb.sv */
/*
 * Small fully associative translation buffer with age based LRU.
 * Assumes the owner serialises lookups and fills on one clock.
 */
`timescale 1ns/1ns
module atc_tlb
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_flush,
  input wire logic [atc_pkg::IDX_W-1:0] i_look_idx,
  input wire logic i_touch,
  input wire logic i_fill,
  input wire atc_pkg::atc_fill_type i_fill_data,
  output logic o_hit,
  output atc_pkg::atc_pte_type o_hit_pte
);
  localparam int N = atc_pkg::TLB_ENTRIES;
  localparam int W = atc_pkg::TLB_IW;

  logic [N-1:0] tag_valid_r;
  logic [atc_pkg::IDX_W-1:0] tag_r [N];
  atc_pkg::atc_pte_type pte_r [N];
  logic [W-1:0] age_r [N];
  logic [W-1:0] hit_way;
  logic [W-1:0] lru_way;
  logic [W-1:0] use_way;

  always_comb
  begin
    o_hit = 1'b0;
    hit_way = '0;
    lru_way = '0;
    for (int i = 0; i < N; i++)
    begin
      if (tag_valid_r[i] && tag_r[i] == i_look_idx)
      begin
        o_hit = 1'b1;
        hit_way = W'(i);
      end
      if (age_r[i] == W'(N - 1))
      begin
        lru_way = W'(i);
      end
    end
    o_hit_pte = pte_r[hit_way];
    use_way = i_fill ? lru_way : hit_way;
  end

  // Flush clears only valid bits; tags and data may stay stale
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b || i_flush)
    begin
      tag_valid_r <= '0;
    end
    else if (i_fill)
    begin
      tag_valid_r[lru_way] <= 1'b1;
    end
  end

  // Invalid table entries are stored like any other
  always_ff @(posedge i_clk_sys)
  begin
    if (i_fill)
    begin
      tag_r[lru_way] <= i_fill_data.idx;
      pte_r[lru_way] <= i_fill_data.pte;
    end
  end

  // Ages stay a permutation, so exactly one way is the oldest
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < N; i++)
      begin
        age_r[i] <= W'(i);
      end
    end
    else if (i_fill || (i_touch && o_hit))
    begin
      for (int i = 0; i < N; i++)
      begin
        if (W'(i) == use_way)
        begin
          age_r[i] <= '0;
        end
        else if (age_r[i] < age_r[use_way])
        begin
          age_r[i] <= age_r[i] + 1'b1;
        end
      end
    end
  end
endmodule : atc_tlb

/* File: tb/atc_assertions.sv */
/* Port checker for the aperture translation control top.
   Assumes one clock and a synchronous active low reset. */
`timescale 1ns/1ns
module atc_assertions
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic [31:0] i_table_base,
  input wire logic o_xl_done,
  input wire logic o_xl_hit_aper,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic o_gwb_flush,
  input wire logic o_aper_32mb
);
  logic [7:0] ctl_r;
  wire logic ctl_wr = i_cfg_wr && i_cfg_addr == 8'hb0;
  wire logic rd_base = i_cfg_rd && i_cfg_addr == 8'h10;
  // Shadow of the control byte, so reads and flushes can be judged
  always_ff @(posedge i_clk_sys)
    if (!i_rst_b)
      ctl_r <= 8'h00;
    else if (ctl_wr)
      ctl_r <= i_cfg_wdata[7:0];
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  property p_flush;
    o_gwb_flush == $past(ctl_wr && i_cfg_wdata[7] != ctl_r[7]);
  endproperty
  a_flush: assert property (p_flush) else $error("bad flush");
  property p_ctl_rd;
    i_cfg_rd && i_cfg_addr == 8'hb0 |=>
      o_cfg_rdata == $past({24'h0, ctl_r[7], 6'h0, ctl_r[0]});
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("bad ctl");
  property p_size_rd;
    i_cfg_rd && i_cfg_addr == 8'hb4 |=>
      o_cfg_rdata == {28'h0, o_aper_32mb, 3'h0};
  endproperty
  a_size_rd: assert property (p_size_rd) else $error("bad size");
  property p_rate_rd;
    ctl_r[0] && i_cfg_rd && i_cfg_addr == 8'ha4 |=> !o_cfg_rdata[2];
  endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("bad rate");
  property p_base25;
    !o_aper_32mb && rd_base |=> !o_cfg_rdata[25];
  endproperty
  a_base25: assert property (p_base25) else $error("bit set");
  property p_base_rw;
    o_aper_32mb && i_cfg_wr && i_cfg_addr == 8'h10 ##1 !i_cfg_wr ##1
      rd_base |=> o_cfg_rdata[25] == $past(i_cfg_wdata[25], 3);
  endproperty
  a_base_rw: assert property (p_base_rw) else $error("bit lost");
  property p_dis_fetch;
    o_xl_done && o_xl_hit_aper && !$past(ctl_r[7]) && !$past(ctl_r[7], 2)
      |-> $past(i_mem_ack);
  endproperty
  a_dis_fetch: assert property (p_dis_fetch)
    else $error("no fetch");
  property p_tbl_align;
    o_mem_req |-> o_mem_addr[1:0] == 2'h0 &&
      o_mem_addr[31:12] - i_table_base[31:12] < 20'h10;
  endproperty
  a_tbl_align: assert property (p_tbl_align)
    else $error("bad addr");
endmodule : atc_assertions
bind atc_top atc_assertions u_chk (.i_clk_sys, .i_rst_b, .i_cfg_wr,
  .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata, .i_table_base,
  .o_xl_done, .o_xl_hit_aper, .o_mem_req, .o_mem_addr, .i_mem_ack,
  .o_gwb_flush, .o_aper_32mb);

/* File: tb/atc_mem_model.sv */
/* Table memory model answering entry fetches after a set delay.
   Assumes fetch requests are held until acknowledged. */
`timescale 1ns/1ns
module atc_mem_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  input wire logic [3:0] i_delay,
  output logic o_mem_ack,
  output logic [31:0] o_mem_data
);
  logic [3:0] wait_r;
  // Idle data toggles so a stale entry never looks right by luck
  always_ff @(posedge i_clk_sys)
  begin
    o_mem_ack <= i_rst_b && i_mem_req && !o_mem_ack && wait_r >= i_delay;
    if (!i_rst_b || o_mem_ack)
      wait_r <= 4'h0;
    else if (i_mem_req && wait_r < i_delay)
      wait_r <= wait_r + 4'h1;
    if (i_mem_req && !o_mem_ack && wait_r >= i_delay)
      o_mem_data <= {i_mem_addr[21:2], 11'h000, ~i_mem_addr[2]};
    else
      o_mem_data <= ~o_mem_data;
  end
endmodule : atc_mem_model

/* File: tb/aperture_translation_control_test.sv */
/* Self-checking bench for the aperture translation control block.
   Assumes the table memory model and the bound port checker. */
`timescale 1ns/1ns
module aperture_translation_control_test;
  logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_xl_req = 1'b0;
  logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, en = 1'b0, sz = 1'b0;
  logic [7:0] i_cfg_addr = 8'h00;
  logic [31:0] i_cfg_wdata = 32'h0, i_xl_addr = 32'h0, base = 32'h0;
  // Low bits set on purpose: the block must drop them
  logic [31:0] i_table_base = 32'h1040_0abc, seed = 32'h63;
  logic [3:0] delay = 4'h0;
  logic [31:0] o_cfg_rdata, o_xl_addr, o_mem_addr, i_mem_data;
  logic o_cfg_rvalid, o_xl_busy, o_xl_done, o_xl_hit_aper, o_xl_fault;
  logic o_mem_req, i_mem_ack, o_gwb_flush, o_aper_32mb;
  logic [2:0] o_rate;
  logic [31:0] adr[10] = '{32'h0c00_2000, 32'h0c00_3000, 32'h0c00_2000,
    32'h0e00_5000, 32'h0c00_3000, 32'h0c00_6000, 32'h2000_0000,
    32'h0c00_2000, 32'h0c00_7000, 32'h0e00_5000};
  int bad_count = 0, compares = 0, cycles = 0, fetches = 0;
  int lru[$];
  always #5 i_clk_sys = ~i_clk_sys;
  atc_top u_dut (.*);
  atc_mem_model u_mem (.i_clk_sys, .i_rst_b, .i_mem_req(o_mem_req),
    .i_mem_addr(o_mem_addr), .i_delay(delay), .o_mem_ack(i_mem_ack),
    .o_mem_data(i_mem_data));
  always @(posedge i_clk_sys)
  begin
    cycles++;
    fetches += i_mem_ack;
    bad_count += int'(cycles == 3000);
    if (cycles == 3000)
      end_sim();
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(string what, logic [31:0] e, logic [31:0] got);
    compares++;
    if (got !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_cfg_wr = 1'b1;
    i_cfg_addr = a;
    i_cfg_wdata = d;
    @(negedge i_clk_sys);
    i_cfg_wr = 1'b0;
    chk("flush", a == 8'hb0 && d[7] != en, o_gwb_flush);
    en = a == 8'hb0 ? d[7] : en;
    sz = a == 8'hb4 ? d[3] : sz;
    base = (a == 8'h10 ? d : base) & {6'h3f, sz, 25'h0};
    if (!en)
      lru.delete();
    @(negedge i_clk_sys);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    i_cfg_rd = 1'b1;
    i_cfg_addr = a;
    @(negedge i_clk_sys);
    i_cfg_rd = 1'b0;
    chk("rvalid", 32'h1, o_cfg_rvalid);
    @(negedge i_clk_sys);
    chk("rvalid", 32'h0, o_cfg_rvalid);
    chk("read", e, o_cfg_rdata);
  endtask : rd
  task automatic xl(logic [31:0] a);
    int idx;
    int f0;
    int m[$];
    logic ap;
    seed = lfsr(seed);
    a[11:0] = seed[11:0];
    delay = seed[15:12];
    ap = sz ? a[31:25] == base[31:25] : a[31:26] == base[31:26];
    idx = sz ? a[24:12] : a[25:12];
    m = lru.find(x) with (x == idx);
    f0 = fetches;
    i_xl_req = 1'b1;
    i_xl_addr = a;
    @(negedge i_clk_sys);
    i_xl_req = 1'b0;
    for (int n = 0; n < 40 && o_xl_done !== 1'b1; n++)
      @(negedge i_clk_sys);
    chk("address", ap ? {idx[19:0], a[11:0]} : a, o_xl_addr);
    chk("aperture", ap, o_xl_hit_aper);
    chk("fault", ap && idx[0], o_xl_fault);
    chk("fetches", ap && !(en && m.size()), fetches - f0);
    chk("busy", 32'h0, o_xl_busy);
    if (ap && en)
    begin
      lru = lru.find(x) with (x != idx);
      lru.push_back(idx);
    end
    if (lru.size() > 4)
      void'(lru.pop_front());
  endtask : xl
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (10) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    rd(8'hb0, 32'h0);
    rd(8'hb4, 32'h0);
    rd(8'ha4, 32'h1);
    chk("rate", 32'h1, o_rate);
    rd(8'h20, 32'h0);
    chk("size", 1'b0, o_aper_32mb);
    $display("reset test done");
    wr(8'hb0, 32'hffff_ffff);
    rd(8'hb0, 32'h81);
    wr(8'ha4, 32'h7);
    wr(8'hb0, 32'h80);
    rd(8'ha4, 32'h3);
    chk("rate", 32'h3, o_rate);
    wr(8'ha4, 32'h4);
    wr(8'hb0, 32'h1);
    rd(8'ha4, 32'h0);
    chk("rate", 32'h0, o_rate);
    wr(8'hb4, 32'hff);
    rd(8'hb4, 32'h8);
    chk("size", 1'b1, o_aper_32mb);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'hfe00_0000);
    wr(8'hb4, 32'h0);
    rd(8'h10, 32'hfc00_0000);
    $display("register test done");
    wr(8'h10, 32'h0c00_0000);
    xl(32'h0c00_2000);
    xl(32'h0c00_2000);
    wr(8'hb0, 32'h80);
    foreach (adr[i])
      xl(adr[i]);
    // Enable cleared at the accepting edge of a lookup that would hit
    fork
      xl(32'h0c00_2000);
      wr(8'hb0, 32'h0);
    join
    wr(8'hb0, 32'h80);
    xl(32'h0c00_2000);
    wr(8'hb4, 32'h8);
    wr(8'h10, 32'h0e00_0000);
    xl(32'h0e00_5000);
    xl(32'h0c00_5000);
    $display("translation test done");
    end_sim();
  end
endmodule : aperture_translation_control_test
